// *** logic/ttcu_consts.svh ***
// register indices, field positions and reset values of the timer unit
`ifndef TTCU_CONSTS_SVH
`define TTCU_CONSTS_SVH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define TTCU_IDX_AB_CTRL   8'h88
`define TTCU_IDX_AB_MODE   8'h89
`define TTCU_IDX_A_LO      8'h8A
`define TTCU_IDX_B_LO      8'h8B
`define TTCU_IDX_A_HI      8'h8C
`define TTCU_IDX_B_HI      8'h8D
`define TTCU_IDX_C_CTRL    8'hC8
`define TTCU_IDX_C_RLD_LO  8'hCA
`define TTCU_IDX_C_RLD_HI  8'hCB
`define TTCU_IDX_C_LO      8'hCC
`define TTCU_IDX_C_HI      8'hCD
// ----------------------------------------
// timers_a_b_control fields
// ----------------------------------------
`define TTCU_B_B_OVF       7
`define TTCU_B_B_RUN       6
`define TTCU_B_A_OVF       5
`define TTCU_B_A_RUN       4
// ----------------------------------------
// timers_a_b_mode fields
// ----------------------------------------
`define TTCU_B_GATE1       7
`define TTCU_B_CT1         6
`define TTCU_B_GATE0       3
`define TTCU_B_CT0         2
// ----------------------------------------
// timer_c_control fields
// ----------------------------------------
`define TTCU_B_C_OVF       7
`define TTCU_B_C_EXT       6
`define TTCU_B_RX_CLK_SEL  5
`define TTCU_B_TX_CLK_SEL  4
`define TTCU_B_C_EXT_EN    3
`define TTCU_B_C_RUN       2
`define TTCU_B_C_CNT_SEL   1
`define TTCU_B_C_CAP_SEL   0
// ----------------------------------------
// reset values
// ----------------------------------------
`define TTCU_RST_BYTE      8'h00
`endif

// *** logic/ttcu_pkg.sv ***
// types shared by the timer unit
`default_nettype none
package ttcu_pkg;
  typedef enum logic [1:0] {
    TTCU_MODE13,
    TTCU_MODE16,
    TTCU_MODE8_RELOAD,
    TTCU_MODE_SPLIT
  } ttcu_ab_mode_e;
  typedef enum logic [1:0] {
    TTCU_C_OFF,
    TTCU_C_RELOAD,
    TTCU_C_CAPTURE,
    TTCU_C_BAUD
  } ttcu_c_mode_e;
endpackage
`default_nettype wire

// *** logic/ttcu_top.sv ***
// three timer/counter unit with apb register access
//
// Function
// - timers a and b each have low and high bytes, separate or joined
// - mode 0 counts 13 bits: high byte plus low five bits of low byte
// - rollover from all ones sets the timer overflow flag
// - count only when run is set and gate is clear or pin high
// - setting run leaves counter bytes untouched
// - counters advance on the core clock with no prescaler, or on count pin falls when selected
// - mode 1 is mode 0 widened to the full 16 bits
// - mode 2 counts low byte, reloads it from high byte on overflow
// - timer b in mode 3 holds its count as if stopped
// - timer a mode 3: low byte own controls, high byte uses b run/flag
// - with a in mode 3, b runs unless in its own mode 3, still baud source
// - timer c mode: off, baud, capture or 16-bit reload from control bits
// - timer c reload mode: rollover sets flag and reloads from reload pair
// - reload mode with external enable: trigger fall reloads, sets external flag
// - capture mode counts 16 bits, sets overflow flag, no reload
// - capture mode with external enable: trigger fall copies counter to pair
// - trigger fall sets timer c external flag when external enable and run are set, usable as interrupt
// - baud mode never sets timer c overflow flag; external flag still works
// - any serial clock select forces timer c reload on its overflow
// - clock selects route timer c overflow to serial, else timer b
// - timer c counter select counts count pin falls, else core clock
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ttcu_consts.svh"
module ttcu_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq_pin_a,
  input  wire logic        ext_irq_pin_b,
  input  wire logic        timer_a_count_pin,
  input  wire logic        timer_b_count_pin,
  input  wire logic        timer_c_count_pin,
  input  wire logic        timer_c_trigger_pin,
  output logic             timer_a_overflow_flag,
  output logic             timer_b_overflow_flag,
  output logic             timer_c_overflow_flag,
  output logic             timer_c_external_flag,
  output logic             serial_rx_clock_tick,
  output logic             serial_tx_clock_tick
);
  // the range check slices paddr above bit 9, so at least one such bit must exist
  if (ADDR_W < 11) begin : g_bad_addr_w
    $error("ttcu_top: ADDR_W must be at least 11");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_fall;
  assign pin_raw = {timer_c_trigger_pin, timer_c_count_pin, timer_b_count_pin,
                    timer_a_count_pin, ext_irq_pin_b, ext_irq_pin_a};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
        end
      end
      assign pin_fall[gi] = pin_s3[gi] & ~pin_s2[gi];
    end
  endgenerate

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic       a_ovf, timer_a_run, b_ovf, timer_b_run;
  logic [7:0] mode_ab;
  logic [7:0] a_lo, a_hi, b_lo, b_hi;
  logic [7:0] c_ctrl;
  logic [7:0] c_lo, c_hi, rld_lo, rld_hi;

  // ----------------------------------------
  // apb slave: one wait state, data from flops
  // ----------------------------------------
  logic       rdy;
  logic [7:0] idx;
  logic       idx_ok;
  logic       wr;
  logic       hit;
  logic [7:0] rd_mux;
  assign idx    = paddr[9:2];
  assign idx_ok = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'h0);
  assign pready = rdy;
  assign wr     = psel & penable & rdy & pwrite;
  assign pslverr = rdy & ~hit;

  function automatic logic wr_to(input logic w, input logic [7:0] i,
                                 input logic ok, input logic [7:0] target);
    return w & ok & (i == target);
  endfunction

  logic wr_abc, wr_abm, wr_alo, wr_ahi, wr_blo, wr_bhi;
  logic wr_cc, wr_clo, wr_chi, wr_rlo, wr_rhi;
  assign wr_abc = wr_to(wr, idx, idx_ok, `TTCU_IDX_AB_CTRL);
  assign wr_abm = wr_to(wr, idx, idx_ok, `TTCU_IDX_AB_MODE);
  assign wr_alo = wr_to(wr, idx, idx_ok, `TTCU_IDX_A_LO);
  assign wr_ahi = wr_to(wr, idx, idx_ok, `TTCU_IDX_A_HI);
  assign wr_blo = wr_to(wr, idx, idx_ok, `TTCU_IDX_B_LO);
  assign wr_bhi = wr_to(wr, idx, idx_ok, `TTCU_IDX_B_HI);
  assign wr_cc  = wr_to(wr, idx, idx_ok, `TTCU_IDX_C_CTRL);
  assign wr_clo = wr_to(wr, idx, idx_ok, `TTCU_IDX_C_LO);
  assign wr_chi = wr_to(wr, idx, idx_ok, `TTCU_IDX_C_HI);
  assign wr_rlo = wr_to(wr, idx, idx_ok, `TTCU_IDX_C_RLD_LO);
  assign wr_rhi = wr_to(wr, idx, idx_ok, `TTCU_IDX_C_RLD_HI);

  always_comb begin
    hit    = idx_ok;
    rd_mux = 8'h00;
    case (idx)
      `TTCU_IDX_AB_CTRL:  rd_mux = {b_ovf, timer_b_run, a_ovf, timer_a_run, 4'h0};
      `TTCU_IDX_AB_MODE:  rd_mux = mode_ab;
      `TTCU_IDX_A_LO:     rd_mux = a_lo;
      `TTCU_IDX_A_HI:     rd_mux = a_hi;
      `TTCU_IDX_B_LO:     rd_mux = b_lo;
      `TTCU_IDX_B_HI:     rd_mux = b_hi;
      `TTCU_IDX_C_CTRL:   rd_mux = c_ctrl;
      `TTCU_IDX_C_RLD_LO: rd_mux = rld_lo;
      `TTCU_IDX_C_RLD_HI: rd_mux = rld_hi;
      `TTCU_IDX_C_LO:     rd_mux = c_lo;
      `TTCU_IDX_C_HI:     rd_mux = c_hi;
      default:            hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdy    <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      rdy <= psel & penable & ~rdy;
      if (psel & penable & ~rdy)
        prdata <= {24'h00_0000, hit ? rd_mux : 8'h00};
    end
  end

  // ----------------------------------------
  // timers a and b
  // ----------------------------------------
  // one step of a joined counter: {overflow, high, low}
  function automatic logic [16:0] ab_step(input ttcu_pkg::ttcu_ab_mode_e m,
                                          input logic [7:0] hi,
                                          input logic [7:0] lo,
                                          input logic inc);
    logic [12:0] c13;
    logic [15:0] c16;
    logic [16:0] r;
    c13 = {hi, lo[4:0]} + 13'h0001;
    c16 = {hi, lo} + 16'h0001;
    r   = {1'b0, hi, lo};
    if (inc) begin
      case (m)
        // upper three low bits just ride along
        ttcu_pkg::TTCU_MODE13:
          r = {({hi, lo[4:0]} == 13'h1FFF), c13[12:5], lo[7:5], c13[4:0]};
        ttcu_pkg::TTCU_MODE16:
          r = {(c16 == 16'h0000), c16};
        ttcu_pkg::TTCU_MODE8_RELOAD:
          r = (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, c16[7:0]};
        default:
          r = {(lo == 8'hFF), hi, c16[7:0]};
      endcase
    end
    return r;
  endfunction

  ttcu_pkg::ttcu_ab_mode_e a_mode, b_mode;
  logic        a_split, b_split;
  logic        a_inc, b_inc, b_run;
  logic [16:0] a_nx, b_nx;
  logic [7:0]  a_hi_hw;
  logic        ah_ovf;
  assign a_mode  = ttcu_pkg::ttcu_ab_mode_e'(mode_ab[1:0]);
  assign b_mode  = ttcu_pkg::ttcu_ab_mode_e'(mode_ab[5:4]);
  assign a_split = (a_mode == ttcu_pkg::TTCU_MODE_SPLIT);
  assign b_split = (b_mode == ttcu_pkg::TTCU_MODE_SPLIT);
  // no prescaler: a timer tick is every core clock
  assign a_inc = timer_a_run & (~mode_ab[`TTCU_B_GATE0] | pin_s2[0])
               & (mode_ab[`TTCU_B_CT0] ? pin_fall[2] : 1'b1);
  // with a split, b loses its run bit and is started by leaving mode 3
  assign b_run = ~b_split & (a_split | timer_b_run);
  assign b_inc = b_run & (~mode_ab[`TTCU_B_GATE1] | pin_s2[1])
               & (mode_ab[`TTCU_B_CT1] ? pin_fall[3] : 1'b1);
  assign a_nx    = ab_step(a_mode, a_hi, a_lo, a_inc);
  assign b_nx    = ab_step(b_mode, b_hi, b_lo, b_inc);
  assign ah_ovf  = a_split & timer_b_run & (a_hi == 8'hFF);
  assign a_hi_hw = a_split ? (timer_b_run ? a_hi + 8'h01 : a_hi) : a_nx[15:8];

  logic next_a_ovf, next_b_ovf;
  // hardware set beats software clear
  assign next_a_ovf = a_nx[16] | (wr_abc ? pwdata[`TTCU_B_A_OVF] : a_ovf);
  assign next_b_ovf = (a_split ? ah_ovf : b_nx[16])
                    | (wr_abc ? pwdata[`TTCU_B_B_OVF] : b_ovf);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      a_ovf       <= 1'b0;
      timer_a_run <= 1'b0;
      b_ovf       <= 1'b0;
      timer_b_run <= 1'b0;
      mode_ab     <= `TTCU_RST_BYTE;
      a_lo        <= `TTCU_RST_BYTE;
      a_hi        <= `TTCU_RST_BYTE;
      b_lo        <= `TTCU_RST_BYTE;
      b_hi        <= `TTCU_RST_BYTE;
    end else begin
      a_ovf <= next_a_ovf;
      b_ovf <= next_b_ovf;
      if (wr_abc) begin
        timer_a_run <= pwdata[`TTCU_B_A_RUN];
        timer_b_run <= pwdata[`TTCU_B_B_RUN];
      end
      if (wr_abm)
        mode_ab <= pwdata[7:0];
      a_lo <= wr_alo ? pwdata[7:0] : a_nx[7:0];
      a_hi <= wr_ahi ? pwdata[7:0] : a_hi_hw;
      b_lo <= wr_blo ? pwdata[7:0] : b_nx[7:0];
      b_hi <= wr_bhi ? pwdata[7:0] : b_nx[15:8];
    end
  end

  // ----------------------------------------
  // timer c
  // ----------------------------------------
  ttcu_pkg::ttcu_c_mode_e c_mode;
  logic        baud, c_inc, c_ovf, trig, do_reload, do_cap;
  logic [15:0] c_cnt, c_rld, c_hw;
  assign baud  = c_ctrl[`TTCU_B_RX_CLK_SEL] | c_ctrl[`TTCU_B_TX_CLK_SEL];
  assign c_mode = !c_ctrl[`TTCU_B_C_RUN] ? ttcu_pkg::TTCU_C_OFF
                : baud ? ttcu_pkg::TTCU_C_BAUD
                : c_ctrl[`TTCU_B_C_CAP_SEL] ? ttcu_pkg::TTCU_C_CAPTURE
                : ttcu_pkg::TTCU_C_RELOAD;
  assign c_cnt = {c_hi, c_lo};
  assign c_rld = {rld_hi, rld_lo};
  assign c_inc = (c_mode != ttcu_pkg::TTCU_C_OFF)
               & (c_ctrl[`TTCU_B_C_CNT_SEL] ? pin_fall[4] : 1'b1);
  assign c_ovf = c_inc & (c_cnt == 16'hFFFF);
  assign trig  = (c_mode != ttcu_pkg::TTCU_C_OFF)
               & c_ctrl[`TTCU_B_C_EXT_EN] & pin_fall[5];
  // serial clocking suppresses trigger reload and capture
  assign do_reload = (c_ovf & (c_mode != ttcu_pkg::TTCU_C_CAPTURE))
                   | (trig & (c_mode == ttcu_pkg::TTCU_C_RELOAD));
  assign do_cap = trig & (c_mode == ttcu_pkg::TTCU_C_CAPTURE);
  assign c_hw   = do_reload ? c_rld : (c_cnt + {15'h0000, c_inc});

  logic next_c_ovf, next_c_ext;
  assign next_c_ovf = (c_ovf & (c_mode != ttcu_pkg::TTCU_C_BAUD))
                    | (wr_cc ? pwdata[`TTCU_B_C_OVF] : c_ctrl[`TTCU_B_C_OVF]);
  assign next_c_ext = trig | (wr_cc ? pwdata[`TTCU_B_C_EXT] : c_ctrl[`TTCU_B_C_EXT]);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      c_ctrl <= `TTCU_RST_BYTE;
      c_lo   <= `TTCU_RST_BYTE;
      c_hi   <= `TTCU_RST_BYTE;
      rld_lo <= `TTCU_RST_BYTE;
      rld_hi <= `TTCU_RST_BYTE;
    end else begin
      c_ctrl <= {next_c_ovf, next_c_ext, wr_cc ? pwdata[5:0] : c_ctrl[5:0]};
      c_lo   <= wr_clo ? pwdata[7:0] : c_hw[7:0];
      c_hi   <= wr_chi ? pwdata[7:0] : c_hw[15:8];
      rld_lo <= wr_rlo ? pwdata[7:0] : (do_cap ? c_lo : rld_lo);
      rld_hi <= wr_rhi ? pwdata[7:0] : (do_cap ? c_hi : rld_hi);
    end
  end

  // ----------------------------------------
  // serial clock ticks and flag outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      serial_rx_clock_tick <= 1'b0;
      serial_tx_clock_tick <= 1'b0;
    end else begin
      serial_rx_clock_tick <= c_ctrl[`TTCU_B_RX_CLK_SEL] ? c_ovf : b_nx[16];
      serial_tx_clock_tick <= c_ctrl[`TTCU_B_TX_CLK_SEL] ? c_ovf : b_nx[16];
    end
  end
  assign timer_a_overflow_flag = a_ovf;
  assign timer_b_overflow_flag = b_ovf;
  assign timer_c_overflow_flag = c_ctrl[`TTCU_B_C_OVF];
  assign timer_c_external_flag = c_ctrl[`TTCU_B_C_EXT];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [15:0] a_cnt16;
  assign a_cnt16 = {a_hi, a_lo};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_access;
    psel & penable & ~pready;
  endsequence
  sequence s_a16_step;
    (a_mode == ttcu_pkg::TTCU_MODE16) & a_inc & ~wr_alo & ~wr_ahi;
  endsequence
  sequence s_a_blocked;
    timer_a_run & mode_ab[`TTCU_B_GATE0] & ~pin_s2[0] & ~a_split & ~wr_alo & ~wr_ahi;
  endsequence

  a_apb_wait_one: assert property (s_access |=> pready)
    else $error("apb answer not one cycle after access");
  a_mode1_count: assert property (s_a16_step |=> a_cnt16 == $past(a_cnt16) + 16'h0001)
    else $error("mode 1 count did not step by one");
  a_gate_blocks: assert property (s_a_blocked |=> $stable(a_cnt16))
    else $error("gated timer a advanced");
  a_ovf_a_wrap: assert property (a_nx[16] |=> a_ovf)
    else $error("timer a overflow flag not set");
  a_mode2_reload: assert property ((a_mode == ttcu_pkg::TTCU_MODE8_RELOAD) & a_inc
    & (a_lo == 8'hFF) & ~wr_alo & ~wr_ahi |=> a_lo == a_hi)
    else $error("mode 2 reload missed");
  a_b_split_hold: assert property (b_split & ~wr_blo & ~wr_bhi
    |=> $stable(b_lo) && $stable(b_hi))
    else $error("timer b moved in mode 3");
  a_c_reload_val: assert property (c_ovf & (c_mode == ttcu_pkg::TTCU_C_RELOAD)
    & ~wr_clo & ~wr_chi |=> c_cnt == $past(c_rld))
    else $error("timer c reload wrong");
  a_c_capture_val: assert property (do_cap & ~wr_rlo & ~wr_rhi
    |=> c_rld == $past(c_cnt) && timer_c_external_flag)
    else $error("timer c capture wrong");
  a_baud_no_ovf: assert property ((c_mode == ttcu_pkg::TTCU_C_BAUD) & ~timer_c_overflow_flag
    & ~wr_cc |=> ~timer_c_overflow_flag)
    else $error("overflow flag set in baud mode");
  a_sw_write_wins: assert property (wr_alo |=> a_lo == $past(pwdata[7:0]))
    else $error("software write lost to counter");
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking testbench of the three timer/counter unit
`timescale 1ns/1ps
`default_nettype none
`include "ttcu_consts.svh"
module tb;
  logic        sys_clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_irq_pin_a;
  logic        ext_irq_pin_b;
  logic        timer_a_count_pin;
  logic        timer_b_count_pin;
  logic        timer_c_count_pin;
  logic        timer_c_trigger_pin;
  logic        timer_a_overflow_flag;
  logic        timer_b_overflow_flag;
  logic        timer_c_overflow_flag;
  logic        timer_c_external_flag;
  logic        serial_rx_clock_tick;
  logic        serial_tx_clock_tick;
  logic        last_err;
  logic [31:0] seed;
  int          err_total;
  int          samples_checked;
  int          tx_ticks;
  int          rx_ticks;

  ttcu_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b), .timer_a_count_pin(timer_a_count_pin),
    .timer_b_count_pin(timer_b_count_pin), .timer_c_count_pin(timer_c_count_pin),
    .timer_c_trigger_pin(timer_c_trigger_pin), .timer_a_overflow_flag(timer_a_overflow_flag),
    .timer_b_overflow_flag(timer_b_overflow_flag), .timer_c_overflow_flag(timer_c_overflow_flag),
    .timer_c_external_flag(timer_c_external_flag), .serial_rx_clock_tick(serial_rx_clock_tick),
    .serial_tx_clock_tick(serial_tx_clock_tick));

  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (serial_tx_clock_tick === 1'h1) tx_ticks++;
    if (serial_rx_clock_tick === 1'h1) rx_ticks++;
  end

  // ----------------------------------------
  // reference models
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // one step per gated core cycle; mode 0 compares only the low five bits
  function automatic void ab_model(input int t, input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi,
                                   input int n, output logic [7:0] elo, output logic [7:0] ehi, output logic f);
    logic [12:0] c13;
    logic [15:0] c16;
    f = 1'h0;
    elo = lo;
    ehi = hi;
    for (int i = 0; i < n; i++) begin
      case (m)
        2'h0: begin
          c13 = {ehi, elo[4:0]} + 13'h1;
          f |= (c13 == 13'h0);
          ehi = c13[12:5];
          elo[4:0] = c13[4:0];
        end
        2'h1: begin
          c16 = {ehi, elo} + 16'h1;
          f |= (c16 == 16'h0);
          {ehi, elo} = c16;
        end
        2'h2: begin
          f |= (elo == 8'hFF);
          elo = (elo == 8'hFF) ? ehi : elo + 8'h1;
        end
        default: if (t == 0) begin
          elo = elo + 8'h1;
          f |= (elo == 8'h0);
        end
      endcase
    end
  endfunction

  function automatic void c_model(input logic [7:0] ctl, input logic [15:0] c0, input logic [15:0] r0,
                                  input int nf, input logic trig, output logic [15:0] c, output logic [15:0] r,
                                  output logic tf, output logic ex, output int ov);
    logic baud;
    logic cap;
    baud = ctl[5] | ctl[4];
    cap = ctl[0] & !baud;
    c = c0;
    r = r0;
    tf = 1'h0;
    ex = 1'h0;
    ov = 0;
    if (ctl[2]) begin
      for (int i = 0; i < nf; i++) begin
        if (c == 16'hFFFF) begin
          ov++;
          tf |= !baud;
          c = cap ? 16'h0 : r;
        end else c = c + 16'h1;
      end
      if (trig && ctl[3]) begin
        ex = 1'h1;
        if (cap) r = c;
        else if (!baud) c = r;
      end
    end
  endfunction

  // ----------------------------------------
  // bus and pin tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'h1 && i < 20);
    if (pready !== 1'h1) begin
      err_total++;
      $display("CHECK FAILED t=%0t no ready", $time);
      summarize();
    end
    d = prdata[7:0];
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] d;
    apb(1'h1, idx, v, d);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    apb(1'h0, idx, 8'h00, d);
  endtask

  task automatic set_pin(input int w, input logic v);
    case (w)
      0: ext_irq_pin_a <= v;
      1: ext_irq_pin_b <= v;
      2: timer_c_count_pin <= v;
      3: timer_c_trigger_pin <= v;
      default: timer_a_count_pin <= v;
    endcase
  endtask

  // idle-high pins: one falling edge, both levels long enough for the synchroniser
  task automatic fall(input int w);
    set_pin(w, 1'h0);
    repeat (3) @(posedge sys_clk);
    set_pin(w, 1'h1);
    repeat (3) @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // gate pin high for n cycles lets exactly n core cycles be counted
  task automatic run_ab(input int t, input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi, input int n);
    logic [7:0] v;
    logic [7:0] elo;
    logic [7:0] ehi;
    logic [7:0] lidx;
    logic [7:0] hidx;
    logic       f;
    lidx = t ? `TTCU_IDX_B_LO : `TTCU_IDX_A_LO;
    hidx = t ? `TTCU_IDX_B_HI : `TTCU_IDX_A_HI;
    ab_model(t, m, lo, hi, n, elo, ehi, f);
    // mode first: a split left by the last run keeps timer b counting over its byte writes
    wr(`TTCU_IDX_AB_MODE, t ? {2'h2, m, 4'h0} : {4'h0, 2'h2, m});
    wr(lidx, lo);
    wr(hidx, hi);
    wr(`TTCU_IDX_AB_CTRL, t ? 8'h40 : 8'h10);
    rd(lidx, v);
    check(v, lo);
    rd(hidx, v);
    check(v, hi);
    set_pin(t, 1'h1);
    repeat (n) @(posedge sys_clk);
    set_pin(t, 1'h0);
    repeat (8) @(posedge sys_clk);
    rd(`TTCU_IDX_AB_CTRL, v);
    check(v, t ? {f, 7'h40} : {2'h0, f, 5'h10});
    check({7'h0, t ? timer_b_overflow_flag : timer_a_overflow_flag}, {7'h0, f});
    rd(lidx, v);
    check(m == 2'h0 ? v & 8'h1F : v, m == 2'h0 ? elo & 8'h1F : elo);
    rd(hidx, v);
    check(v, ehi);
    wr(`TTCU_IDX_AB_CTRL, 8'h00);
  endtask

  task automatic run_c(input logic [7:0] ctl, input logic [15:0] c0, input logic [15:0] r0, input int nf,
                       input logic trig);
    logic [7:0]  v;
    logic [15:0] c;
    logic [15:0] r;
    logic        tf;
    logic        ex;
    int          ov;
    c_model(ctl, c0, r0, nf, trig, c, r, tf, ex, ov);
    wr(`TTCU_IDX_C_LO, c0[7:0]);
    wr(`TTCU_IDX_C_HI, c0[15:8]);
    wr(`TTCU_IDX_C_RLD_LO, r0[7:0]);
    wr(`TTCU_IDX_C_RLD_HI, r0[15:8]);
    wr(`TTCU_IDX_C_CTRL, ctl);
    tx_ticks = 0;
    rx_ticks = 0;
    repeat (nf) fall(2);
    if (trig) fall(3);
    repeat (6) @(posedge sys_clk);
    rd(`TTCU_IDX_C_CTRL, v);
    check(v, {tf, ex, ctl[5:0]});
    check({6'h0, timer_c_overflow_flag, timer_c_external_flag}, {6'h0, tf, ex});
    rd(`TTCU_IDX_C_LO, v);
    check(v, c[7:0]);
    rd(`TTCU_IDX_C_HI, v);
    check(v, c[15:8]);
    rd(`TTCU_IDX_C_RLD_LO, v);
    check(v, r[7:0]);
    rd(`TTCU_IDX_C_RLD_HI, v);
    check(v, r[15:8]);
    check(8'(tx_ticks), ctl[4] ? 8'(ov) : 8'h00);
    check(8'(rx_ticks), ctl[5] ? 8'(ov) : 8'h00);
    wr(`TTCU_IDX_C_CTRL, 8'h00);
  endtask

  initial begin
    logic [7:0]  v;
    logic [31:0] r;
    logic [7:0]  ridx [11];
    logic [7:0]  ctab [6];
    ridx = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
    // reload, capture, tx baud, rx baud with capture ignored, trigger disabled, stopped
    ctab = '{8'h0E, 8'h0F, 8'h1E, 8'h2F, 8'h06, 8'h0A};
    seed = 32'hEB54;
    err_total = 0;
    samples_checked = 0;
    tx_ticks = 0;
    rx_ticks = 0;
    nrst = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ext_irq_pin_a = 1'h0;
    ext_irq_pin_b = 1'h0;
    timer_a_count_pin = 1'h1;
    timer_b_count_pin = 1'h1;
    timer_c_count_pin = 1'h1;
    timer_c_trigger_pin = 1'h1;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'h1;
    @(posedge sys_clk);
    foreach (ridx[i]) begin
      rd(ridx[i], v);
      check(v, `TTCU_RST_BYTE);
    end
    rd(8'h90, v);
    check({7'h0, last_err}, 8'h01);
    check(v, 8'h00);
    run_ab(0, 2'h1, 8'hFF, 8'hFF, 1);
    run_ab(1, 2'h2, 8'hFF, 8'h5A, 1);
    for (int rep = 0; rep < 2; rep++) begin
      for (int t = 0; t < 2; t++) begin
        for (int m = 0; m < 4; m++) begin
          r = xs();
          run_ab(t, 2'(m), {3'h7, r[4:0]}, m == 2 ? r[15:8] : 8'hFF, 1 + int'(r[21:16] % 48));
        end
      end
    end
    // split: high byte of a runs on b's run bit for the 4 edges up to the mode write; b parked
    wr(`TTCU_IDX_AB_MODE, 8'h33);
    wr(`TTCU_IDX_A_LO, 8'h11);
    wr(`TTCU_IDX_A_HI, 8'hFE);
    wr(`TTCU_IDX_AB_CTRL, 8'h40);
    wr(`TTCU_IDX_AB_MODE, 8'h30);
    rd(`TTCU_IDX_AB_CTRL, v);
    check(v, 8'hC0);
    rd(`TTCU_IDX_A_HI, v);
    check(v, 8'h02);
    rd(`TTCU_IDX_A_LO, v);
    check(v, 8'h11);
    // timer a as a counter of falls on its count pin
    wr(`TTCU_IDX_AB_CTRL, 8'h00);
    wr(`TTCU_IDX_AB_MODE, 8'h05);
    wr(`TTCU_IDX_A_LO, 8'hFE);
    wr(`TTCU_IDX_A_HI, 8'hFF);
    wr(`TTCU_IDX_AB_CTRL, 8'h10);
    repeat (3) fall(4);
    rd(`TTCU_IDX_A_LO, v);
    check(v, 8'h01);
    rd(`TTCU_IDX_AB_CTRL, v);
    check(v, 8'h30);
    wr(`TTCU_IDX_AB_CTRL, 8'h00);
    for (int rep = 0; rep < 2; rep++) begin
      foreach (ctab[i]) begin
        r = xs();
        run_c(ctab[i], {8'hFF, 5'h1F, r[2:0]}, r[31:16], 1 + int'(r[7:4] % 10), rep == 1 || r[8]);
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
